/* rtl/cpfc_defs.svh */
`ifndef CPFC_DEFS_SVH
`define CPFC_DEFS_SVH

// register byte addresses
`define CPFC_ADDR_UPD_TIMING 32'hf1000570
`define CPFC_ADDR_AVG_BIN 32'hf10005b0
`define CPFC_ADDR_PERSIST 32'hf1000640

// field positions, data bit 31 is the leftmost documented bit
`define CPFC_PRESENT_BIT 31
`define CPFC_SESSION_BIT 25
`define CPFC_TIMING_MSB 7
`define CPFC_TIMING_LSB 0
`define CPFC_AVG_EN_BIT 25
`define CPFC_BLANK_BIT 14
`define CPFC_TAP_MSB 13
`define CPFC_TAP_LSB 10

// mode encodings
`define CPFC_TIMING_STD 8'h00
`define CPFC_TIMING_QUICK 8'h02

// reset values
`define CPFC_TIMING_RST 8'h00
`define CPFC_SESSION_RST 1'b0
`define CPFC_AVG_EN_RST 1'b0
`define CPFC_BLANK_RST 1'b0
`define CPFC_TAP_RST 4'h0

// timing
`define CPFC_CLK_HZ 10000000
`define CPFC_SESSION_TIMEOUT_S 10

`endif

/* rtl/cpfc_pkg.sv */
package cpfc_pkg;

    typedef enum logic [2:0] {
        CPFC_IDLE = 3'b001,
        CPFC_OPEN = 3'b010,
        CPFC_WAIT = 3'b100
    } cpfc_sess_t;

    typedef struct packed {
        logic led;
    } cpfc_led_state_t;

endpackage

/* rtl/cpfc_tmr_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface cpfc_tmr_if;
    logic start;
    logic stop;
    logic expired;
    logic running;

    modport owner (
        output start,
        output stop,
        input expired,
        input running
    );

    modport timer (
        input start,
        input stop,
        output expired,
        output running
    );
endinterface

`default_nettype wire

/* rtl/cpfc_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module cpfc_timer #(
    parameter int CNT_W = 27,
    parameter int LIMIT = 100000000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    cpfc_tmr_if.timer tmr
);
    typedef struct packed {
        logic running;
        logic expired;
        logic [CNT_W-1:0] cnt;
    } cpfc_tmr_state_t;

    cpfc_tmr_state_t s_reg;
    cpfc_tmr_state_t s_next;

    always_comb
    begin
        s_next = s_reg;
        s_next.expired = 1'b0;
        // a start always reloads, so repeated writes push the deadline out
        if (tmr.start)
        begin
            s_next.running = 1'b1;
            s_next.cnt = CNT_W'(LIMIT - 1);
        end
        else if (tmr.stop)
        begin
            s_next.running = 1'b0;
        end
        else if (s_reg.running)
        begin
            if (s_reg.cnt == '0)
            begin
                s_next.running = 1'b0;
                s_next.expired = 1'b1;
            end
            else
            begin
                s_next.cnt = s_reg.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign tmr.expired = s_reg.expired;
    assign tmr.running = s_reg.running;
endmodule

`default_nettype wire

/* rtl/cpfc_indicator.sv */
`timescale 1ns/1ps
`default_nettype none

module cpfc_indicator (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic blank_i,
    input wire logic startup_i,
    input wire logic error_i,
    input wire logic led_normal_i,
    output logic led_o
);
    cpfc_pkg::cpfc_led_state_t s_reg;
    cpfc_pkg::cpfc_led_state_t s_next;

    always_comb
    begin
        s_next = s_reg;
        if (blank_i && !startup_i && !error_i)
        begin
            s_next.led = 1'b0;
        end
        else
        begin
            s_next.led = led_normal_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign led_o = s_reg.led;

    blank_dark_a: assert property (@(posedge clk_i) disable iff (rst_i)
        blank_i && !startup_i && !error_i |=> !led_o)
        else $error("led lit while blanked");

    blank_override_a: assert property (@(posedge clk_i) disable iff (rst_i)
        startup_i || error_i |=> led_o == $past(led_normal_i))
        else $error("led not normal during startup or error");
endmodule

`default_nettype wire

/* rtl/cpfc_top.sv */
// Function
// - timing field zero standard, two quick
// - session flag resets zero, write opens/closes
// - standard mode ignores the session flag
// - quick mode: finish transfer, abort integration
// - flag-one write starts or restarts timeout
// - timeout clears flag and applies pending changes
// - bit zero is read-only presence indication
// - averaging enable makes binning average pixels
// - blanking hides normal indications, except during startup and errors
// - startup and errors keep normal indications
// - tap select zero single, one dual
// - sensor tap field reports taps minus one
// - persistent settings kept in non-volatile storage
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "cpfc_defs.svh"

module cpfc_top #(
    parameter int PIX_W = 16,
    parameter int TIMEOUT_CYCLES = `CPFC_SESSION_TIMEOUT_S * `CPFC_CLK_HZ,
    parameter int TMR_W = 27,
    parameter logic UPD_PRESENT = 1'b1,
    parameter logic AVG_PRESENT = 1'b1,
    parameter logic PERSIST_PRESENT = 1'b1,
    parameter logic BLANK_PRESENT = 1'b1,
    parameter logic TAP_SEL_PRESENT = 1'b1,
    parameter logic TAP_CNT_PRESENT = 1'b1,
    parameter logic [3:0] SENSOR_TAPS_M1 = 4'h1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [31:0] rd_data_o,
    input wire logic integration_active_i,
    input wire logic transfer_active_i,
    output logic integration_abort_o,
    output logic params_commit_o,
    output logic session_open_o,
    output logic [7:0] update_timing_select_o,
    output logic averaging_enable_o,
    input wire logic pix_valid_i,
    input wire logic [PIX_W-1:0] pix_a_i,
    input wire logic [PIX_W-1:0] pix_b_i,
    output logic bin_valid_o,
    output logic [PIX_W:0] bin_pix_o,
    input wire logic startup_i,
    input wire logic error_active_i,
    input wire logic led_normal_i,
    output logic led_o,
    output logic [3:0] readout_tap_select_o,
    input wire logic nv_load_i,
    input wire logic [31:0] nv_load_data_i,
    output logic nv_store_o,
    output logic [31:0] nv_store_data_o
);
    typedef struct packed {
        cpfc_pkg::cpfc_sess_t st;
        logic [7:0] timing;
        logic session;
        logic bin_act;
        logic bin_shd;
        logic blank;
        logic [3:0] tap;
        logic abort;
        logic commit;
        logic nv_store;
        logic [31:0] nv_data;
        logic [31:0] rd_data;
        logic bin_valid;
        logic [PIX_W:0] bin_pix;
    } cpfc_top_state_t;

    localparam cpfc_top_state_t ST_RST = '{
        st: cpfc_pkg::CPFC_IDLE,
        timing: `CPFC_TIMING_RST,
        session: `CPFC_SESSION_RST,
        bin_act: `CPFC_AVG_EN_RST,
        bin_shd: `CPFC_AVG_EN_RST,
        blank: `CPFC_BLANK_RST,
        tap: `CPFC_TAP_RST,
        default: '0
    };

    cpfc_top_state_t s_reg;
    cpfc_top_state_t s_next;

    cpfc_tmr_if tmr ();

    logic quick;
    logic wr_upd;
    logic commit_req;
    logic opening;
    logic expire_hit;
    logic tmr_start;
    logic tmr_stop;
    logic [PIX_W:0] pix_sum;
    logic [PIX_W:0] pix_avg;

    function automatic logic [31:0] upd_image(input logic session, input logic [7:0] timing);
        upd_image = {UPD_PRESENT, 5'h00, session, 17'h00000, timing};
    endfunction

    function automatic logic [31:0] avg_image(input logic en);
        avg_image = {AVG_PRESENT, 5'h00, en, 25'h0000000};
    endfunction

    function automatic logic [31:0] pers_image(input logic blank, input logic [3:0] tap);
        pers_image = {PERSIST_PRESENT, BLANK_PRESENT, TAP_SEL_PRESENT, 3'h0, TAP_CNT_PRESENT,
                      9'h000, 1'b0, blank, tap, SENSOR_TAPS_M1, 6'h00};
    endfunction

    assign quick = (s_reg.timing == `CPFC_TIMING_QUICK);
    assign wr_upd = wr_en_i && (addr_i == `CPFC_ADDR_UPD_TIMING);
    assign pix_sum = {1'b0, pix_a_i} + {1'b0, pix_b_i};
    assign pix_avg = {1'b0, pix_sum[PIX_W:1]};

    always_comb
    begin
        s_next = s_reg;
        s_next.commit = 1'b0;
        s_next.nv_store = 1'b0;
        s_next.rd_data = 32'h00000000;
        commit_req = 1'b0;
        opening = 1'b0;
        tmr_start = 1'b0;
        tmr_stop = 1'b0;
        // a flag-one write in the expiry cycle wins over the expiry
        expire_hit = tmr.expired && s_reg.session && quick && !wr_upd;

        if (expire_hit)
        begin
            s_next.session = 1'b0;
            commit_req = 1'b1;
        end

        if (wr_upd)
        begin
            s_next.timing = wr_data_i[`CPFC_TIMING_MSB:`CPFC_TIMING_LSB];
            s_next.session = wr_data_i[`CPFC_SESSION_BIT];
            if (s_next.timing == `CPFC_TIMING_QUICK)
            begin
                if (s_next.session)
                begin
                    tmr_start = 1'b1;
                    opening = 1'b1;
                end
                else if (s_reg.st == cpfc_pkg::CPFC_OPEN)
                begin
                    commit_req = 1'b1;
                    tmr_stop = 1'b1;
                end
            end
            // standard mode flag has no effect
            else if (s_reg.st == cpfc_pkg::CPFC_OPEN)
            begin
                commit_req = 1'b1;
                tmr_stop = 1'b1;
            end
        end

        if (wr_en_i && addr_i == `CPFC_ADDR_AVG_BIN)
        begin
            s_next.bin_shd = wr_data_i[`CPFC_AVG_EN_BIT];
            // shadow while a session is open
            if (s_reg.st == cpfc_pkg::CPFC_IDLE)
            begin
                s_next.bin_act = wr_data_i[`CPFC_AVG_EN_BIT];
            end
        end

        if (wr_en_i && addr_i == `CPFC_ADDR_PERSIST)
        begin
            s_next.blank = wr_data_i[`CPFC_BLANK_BIT];
            s_next.tap = wr_data_i[`CPFC_TAP_MSB:`CPFC_TAP_LSB];
            s_next.nv_store = 1'b1;
            s_next.nv_data = pers_image(s_next.blank, s_next.tap);
        end
        else if (nv_load_i)
        begin
            s_next.blank = nv_load_data_i[`CPFC_BLANK_BIT];
            s_next.tap = nv_load_data_i[`CPFC_TAP_MSB:`CPFC_TAP_LSB];
        end

        s_next.abort = commit_req && integration_active_i;

        case (s_reg.st)
            cpfc_pkg::CPFC_IDLE:
            begin
                if (opening)
                begin
                    s_next.st = cpfc_pkg::CPFC_OPEN;
                end
            end
            cpfc_pkg::CPFC_OPEN:
            begin
                if (commit_req)
                begin
                    s_next.st = cpfc_pkg::CPFC_WAIT;
                end
            end
            cpfc_pkg::CPFC_WAIT:
            begin
                if (!transfer_active_i)
                begin
                    s_next.bin_act = s_next.bin_shd;
                    s_next.commit = 1'b1;
                    if (s_next.session && s_next.timing == `CPFC_TIMING_QUICK)
                    begin
                        s_next.st = cpfc_pkg::CPFC_OPEN;
                    end
                    else
                    begin
                        s_next.st = cpfc_pkg::CPFC_IDLE;
                    end
                end
            end
            default: s_next.st = cpfc_pkg::CPFC_IDLE;
        endcase

        if (rd_en_i)
        begin
            case (addr_i)
                `CPFC_ADDR_UPD_TIMING: s_next.rd_data = upd_image(s_reg.session, s_reg.timing);
                `CPFC_ADDR_AVG_BIN: s_next.rd_data = avg_image(s_reg.bin_shd);
                `CPFC_ADDR_PERSIST: s_next.rd_data = pers_image(s_reg.blank, s_reg.tap);
                default: s_next.rd_data = 32'h00000000;
            endcase
        end

        s_next.bin_valid = pix_valid_i;
        if (pix_valid_i)
        begin
            s_next.bin_pix = s_reg.bin_act ? pix_avg : pix_sum;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_reg <= ST_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign tmr.start = tmr_start;
    assign tmr.stop = tmr_stop;

    cpfc_timer #(.CNT_W(TMR_W), .LIMIT(TIMEOUT_CYCLES)) u_timer (.clk_i(clk_i), .rst_i(rst_i), .tmr(tmr));

    cpfc_indicator u_led (.clk_i(clk_i), .rst_i(rst_i), .blank_i(s_reg.blank), .startup_i(startup_i),
        .error_i(error_active_i), .led_normal_i(led_normal_i), .led_o(led_o));

    assign rd_data_o = s_reg.rd_data;
    assign integration_abort_o = s_reg.abort;
    assign params_commit_o = s_reg.commit;
    assign session_open_o = s_reg.session;
    assign update_timing_select_o = s_reg.timing;
    assign averaging_enable_o = s_reg.bin_act;
    assign bin_valid_o = s_reg.bin_valid;
    assign bin_pix_o = s_reg.bin_pix;
    assign readout_tap_select_o = s_reg.tap;
    assign nv_store_o = s_reg.nv_store;
    assign nv_store_data_o = s_reg.nv_data;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    session_read_a: assert property (
        rd_en_i && addr_i == `CPFC_ADDR_UPD_TIMING |=> rd_data_o[`CPFC_SESSION_BIT] == $past(session_open_o))
        else $error("session flag read wrong");

    std_mode_idle_a: assert property (
        s_reg.st == cpfc_pkg::CPFC_OPEN |-> update_timing_select_o == `CPFC_TIMING_QUICK)
        else $error("session open outside quick mode");

    timer_restart_a: assert property (
        wr_upd && wr_data_i[`CPFC_SESSION_BIT] && wr_data_i[7:0] == `CPFC_TIMING_QUICK |=> tmr.running)
        else $error("timeout not started");

    expiry_clear_a: assert property (
        expire_hit |=> !session_open_o ##[1:64] params_commit_o || transfer_active_i)
        else $error("expiry did not close session");

    abort_pulse_a: assert property (
        commit_req && integration_active_i |=> integration_abort_o ##1 !integration_abort_o)
        else $error("integration not aborted");

    transfer_hold_a: assert property (
        params_commit_o |-> !$past(transfer_active_i))
        else $error("commit during transfer");

    average_out_a: assert property (
        pix_valid_i && averaging_enable_o |=> bin_pix_o == $past(pix_avg))
        else $error("binning did not average");

    presence_ro_a: assert property (
        rd_en_i && addr_i == `CPFC_ADDR_PERSIST |=> rd_data_o[`CPFC_PRESENT_BIT] == PERSIST_PRESENT)
        else $error("presence bit wrong");

    reserved_zero_a: assert property (
        rd_en_i && addr_i == `CPFC_ADDR_AVG_BIN |=> rd_data_o[24:0] == 25'h0000000)
        else $error("reserved bits not zero");

    shadow_hold_a: assert property (
        s_reg.st == cpfc_pkg::CPFC_OPEN && wr_en_i && addr_i == `CPFC_ADDR_AVG_BIN
        |=> averaging_enable_o == $past(averaging_enable_o))
        else $error("shadowed write applied early");
endmodule

`default_nettype wire

/* testbench/cpfc_host.sv */
`timescale 1ns/1ps
`default_nettype none

module cpfc_host (
    input wire logic clk_i,
    input wire logic [31:0] rd_data_i,
    output logic [31:0] addr_o,
    output logic [31:0] wr_data_o,
    output logic wr_en_o,
    output logic rd_en_o
);
    initial
    begin
        addr_o = 32'h0;
        wr_data_o = 32'h0;
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
    end

    // released bus shows the inverse so stale data cannot pass
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wr_data_o <= d;
        wr_en_o <= 1'b1;
        @(posedge clk_i);
        wr_en_o <= 1'b0;
        wr_data_o <= ~d;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_en_o <= 1'b1;
        @(posedge clk_i);
        rd_en_o <= 1'b0;
        @(negedge clk_i);
        d = rd_data_i;
    endtask
endmodule

`default_nettype wire

/* testbench/cpfc_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpfc_defs.svh"

module cpfc_top_bench;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } cpfc_row_t;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] addr;
    logic [31:0] wr_data;
    logic [31:0] rd_data;
    logic wr_en;
    logic rd_en;
    logic integration_active_i = 1'b0;
    logic transfer_active_i = 1'b0;
    logic integration_abort_o;
    logic params_commit_o;
    logic session_open_o;
    logic [7:0] timing_sel;
    logic averaging_enable_o;
    logic pix_valid_i = 1'b0;
    logic [15:0] pix_a_i = 16'h0;
    logic [15:0] pix_b_i = 16'h0;
    logic bin_valid_o;
    logic [16:0] bin_pix_o;
    logic startup_i = 1'b0;
    logic error_active_i = 1'b0;
    logic led_normal_i = 1'b1;
    logic led_o;
    logic [3:0] readout_tap_select_o;
    logic nv_load_i = 1'b0;
    logic [31:0] nv_load_data_i = 32'h0;
    logic nv_store_o;
    logic [31:0] nv_store_data_o;
    logic [31:0] got;
    int n_fail = 0;
    int total_checks = 0;
    int n_abort = 0;
    int n_commit = 0;
    int used;
    cpfc_row_t rows [9];

    always #50 clk_i = ~clk_i;

    always @(posedge clk_i)
    begin
        if (integration_abort_o === 1'b1)
            n_abort <= n_abort + 1;
        if (params_commit_o === 1'b1)
            n_commit <= n_commit + 1;
    end

    cpfc_host i_cpfc_host (.clk_i(clk_i), .rd_data_i(rd_data), .addr_o(addr), .wr_data_o(wr_data),
        .wr_en_o(wr_en), .rd_en_o(rd_en));

    // short watchdog keeps the session runs brief
    cpfc_top #(.TIMEOUT_CYCLES(50)) i_cpfc_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr),
        .wr_data_i(wr_data), .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data),
        .integration_active_i(integration_active_i), .transfer_active_i(transfer_active_i),
        .integration_abort_o(integration_abort_o), .params_commit_o(params_commit_o),
        .session_open_o(session_open_o), .update_timing_select_o(timing_sel),
        .averaging_enable_o(averaging_enable_o),
        .pix_valid_i(pix_valid_i), .pix_a_i(pix_a_i), .pix_b_i(pix_b_i), .bin_valid_o(bin_valid_o),
        .bin_pix_o(bin_pix_o), .startup_i(startup_i), .error_active_i(error_active_i),
        .led_normal_i(led_normal_i), .led_o(led_o), .readout_tap_select_o(readout_tap_select_o),
        .nv_load_i(nv_load_i), .nv_load_data_i(nv_load_data_i), .nv_store_o(nv_store_o),
        .nv_store_data_o(nv_store_data_o));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic results();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wait_commit(input int lim);
        used = 0;
        while (params_commit_o !== 1'b1)
        begin
            @(negedge clk_i);
            used++;
            if (used > lim)
            begin
                n_fail++;
                results();
            end
        end
    endtask

    initial
    begin
        rows[0] = '{`CPFC_ADDR_UPD_TIMING, 32'hfdffff00, 32'h80000000};
        rows[1] = '{`CPFC_ADDR_UPD_TIMING, 32'h00000002, 32'h80000002};
        rows[2] = '{`CPFC_ADDR_UPD_TIMING, 32'h02000000, 32'h82000000};
        rows[3] = '{`CPFC_ADDR_UPD_TIMING, 32'h00000000, 32'h80000000};
        rows[4] = '{`CPFC_ADDR_AVG_BIN, 32'hffffffff, 32'h82000000};
        rows[5] = '{`CPFC_ADDR_AVG_BIN, 32'h00000000, 32'h80000000};
        rows[6] = '{`CPFC_ADDR_PERSIST, 32'hffffffff, 32'he2007c40};
        rows[7] = '{`CPFC_ADDR_PERSIST, 32'h00000000, 32'he2000040};
        rows[8] = '{32'hf1000574, 32'hffffffff, 32'h00000000};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk(session_open_o, 0);
        i_cpfc_host.rd(`CPFC_ADDR_UPD_TIMING, got);
        chk(got, 32'h80000000);
        for (int i = 0; i < 9; i++)
        begin
            i_cpfc_host.wr(rows[i].addr, rows[i].wdata);
            i_cpfc_host.rd(rows[i].addr, got);
            chk(got, rows[i].exp);
        end
        // flag set in standard mode must not hold back binning writes
        i_cpfc_host.wr(`CPFC_ADDR_UPD_TIMING, 32'h02000000);
        for (int k = 0; k < 2; k++)
        begin
            i_cpfc_host.wr(`CPFC_ADDR_AVG_BIN, k ? 32'h0 : 32'h02000000);
            @(negedge clk_i);
            chk(averaging_enable_o, k ? 0 : 1);
            @(posedge clk_i);
            pix_valid_i <= 1'b1;
            pix_a_i <= 16'hffff;
            pix_b_i <= 16'h0003;
            @(posedge clk_i);
            pix_valid_i <= 1'b0;
            @(negedge clk_i);
            chk(bin_pix_o, k ? 17'h10002 : 17'h08001);
            chk(bin_valid_o, 1);
        end
        // session closed by the host while a frame is still leaving
        i_cpfc_host.wr(`CPFC_ADDR_UPD_TIMING, 32'h00000002);
        i_cpfc_host.wr(`CPFC_ADDR_UPD_TIMING, 32'h02000002);
        @(negedge clk_i);
        chk(session_open_o, 1);
        chk(timing_sel, 8'h02);
        i_cpfc_host.wr(`CPFC_ADDR_AVG_BIN, 32'h02000000);
        @(negedge clk_i);
        chk(averaging_enable_o, 0);
        @(posedge clk_i);
        integration_active_i <= 1'b1;
        transfer_active_i <= 1'b1;
        i_cpfc_host.wr(`CPFC_ADDR_UPD_TIMING, 32'h00000002);
        repeat (4) @(negedge clk_i);
        chk(n_abort, 1);
        chk(n_commit, 0);
        @(posedge clk_i);
        transfer_active_i <= 1'b0;
        integration_active_i <= 1'b0;
        wait_commit(10);
        chk(averaging_enable_o, 1);
        chk(session_open_o, 0);
        // watchdog restarted part way, then left to expire
        i_cpfc_host.wr(`CPFC_ADDR_UPD_TIMING, 32'h02000002);
        i_cpfc_host.wr(`CPFC_ADDR_AVG_BIN, 32'h0);
        repeat (30) @(posedge clk_i);
        i_cpfc_host.wr(`CPFC_ADDR_UPD_TIMING, 32'h02000002);
        repeat (40) @(posedge clk_i);
        @(negedge clk_i);
        chk(session_open_o, 1);
        chk(averaging_enable_o, 1);
        wait_commit(20);
        chk(averaging_enable_o, 0);
        i_cpfc_host.rd(`CPFC_ADDR_UPD_TIMING, got);
        chk(got, 32'h80000002);
        // blanking: only startup and errors reach the indicator
        i_cpfc_host.wr(`CPFC_ADDR_PERSIST, 32'h00004000);
        @(negedge clk_i);
        chk(nv_store_o, 1);
        chk(nv_store_data_o, 32'he2004040);
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk_i);
            startup_i <= (k == 2);
            error_active_i <= (k == 1);
            repeat (2) @(posedge clk_i);
            @(negedge clk_i);
            chk(led_o, k != 0);
        end
        // reboot after a tap change is left to the host
        @(posedge clk_i);
        nv_load_i <= 1'b1;
        nv_load_data_i <= 32'h00000400;
        @(posedge clk_i);
        nv_load_i <= 1'b0;
        @(negedge clk_i);
        chk(readout_tap_select_o, 1);
        i_cpfc_host.rd(`CPFC_ADDR_PERSIST, got);
        chk(got, 32'he2000440);
        // host reboots after tap change, storage reloads it
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk(readout_tap_select_o, 0);
        chk(session_open_o, 0);
        chk(timing_sel, 8'h00);
        @(posedge clk_i);
        nv_load_i <= 1'b1;
        @(posedge clk_i);
        nv_load_i <= 1'b0;
        @(negedge clk_i);
        chk(readout_tap_select_o, 1);
        results();
    end
endmodule

`default_nettype wire
